// ### cspr_pkg.sv
// Purpose: Shared constants for the core stack and data pointer register bank.
// Assumes: APB slave with 32-bit data; one aligned word per register.
// Notes:   Printed register offsets are not multiples of four, so they are indices.
`default_nettype none
package cspr_pkg;
  // Register indices as printed in the special function register space.
  localparam logic [7:0] IDX_STACK_TOP    = 8'h81;
  localparam logic [7:0] IDX_PTR_LOW      = 8'h82;
  localparam logic [7:0] IDX_PTR_HIGH     = 8'h83;
  // Extra control register for the core-side operations, index of our own.
  localparam logic [7:0] IDX_OP_CTRL      = 8'h84;
  // Reset values.
  localparam logic [7:0] RST_STACK_TOP    = 8'h07;
  localparam logic [7:0] RST_PTR_BYTE     = 8'h00;
  // Address width and word shift for index to byte address conversion.
  localparam int         ADDR_W           = 12;
  localparam int         WORD_SHIFT       = 2;
  // Fields of the operation control register.
  localparam int         OP_PUSH_BIT      = 0;
  localparam int         OP_PTR_INC_BIT   = 1;
  localparam int         OP_DATA_LSB      = 8;
  localparam logic [7:0] STACK_STEP       = 8'h01;
  localparam logic [15:0] PTR_STEP        = 16'h0001;
endpackage
`default_nettype wire

// ### cspr_regs.sv
// Purpose: Stack top pointer and sixteen-bit data pointer registers behind APB.
// Assumes: Single clock, asynchronous active-high reset, synchronous inputs.
// Notes:   Registers answer on every page; there is no page select input.
//          A control word pushes a byte or steps the data pointer word by one.
//          Read data and the error flag are combinational, so no wait state is needed.
//
// Overview of operation
// - Stack top pointer is eight-bit read/write, reset to 0x07.
// - Each push increments stack top pointer first, then writes byte at new location.
// - Low byte register supplies bits 7 to 0 of data pointer word.
// - High byte supplies bits 15 to 8; both read/write, reset to zero.
// - Data pointer word addresses indirect external data RAM and flash accesses.
`default_nettype none
module cspr_regs (
  // Clock and reset.
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // APB slave.
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Core-side push request and its data.
  input  wire logic        push_req_in,
  input  wire logic [7:0]  push_data_in,
  output logic             stack_wr_out,
  output logic      [7:0]  stack_addr_out,
  output logic      [7:0]  stack_data_out,
  // Indirect access address for external data RAM and flash.
  output logic      [15:0] data_pointer_word_out
);
  // Width of the byte address seen on the bus.
  localparam int ADDR_W = cspr_pkg::ADDR_W;

  logic [7:0]  stack_top_pointer;
  logic [7:0]  pointer_low_byte;
  logic [7:0]  pointer_high_byte;
  logic [7:0]  next_stack_top_pointer;
  logic [7:0]  next_pointer_low_byte;
  logic [7:0]  next_pointer_high_byte;
  logic        next_stack_wr;
  logic [7:0]  next_stack_data;
  logic        stack_wr;
  logic [7:0]  stack_data;
  logic [31:0] next_prdata;
  logic        access;
  logic        wr_en;
  logic        hit_sp;
  logic        hit_lo;
  logic        hit_hi;
  logic        hit_op;
  logic        mapped;
  logic        push_now;
  logic        inc_now;
  logic [15:0] inc_word;

  // Address decode of the APB access phase; index times four is the byte address.
  always_comb begin
    access = psel_in && penable_in;
    hit_sp = paddr_in == (ADDR_W'(cspr_pkg::IDX_STACK_TOP) << cspr_pkg::WORD_SHIFT);
    hit_lo = paddr_in == (ADDR_W'(cspr_pkg::IDX_PTR_LOW) << cspr_pkg::WORD_SHIFT);
    hit_hi = paddr_in == (ADDR_W'(cspr_pkg::IDX_PTR_HIGH) << cspr_pkg::WORD_SHIFT);
    hit_op = paddr_in == (ADDR_W'(cspr_pkg::IDX_OP_CTRL) << cspr_pkg::WORD_SHIFT);
    mapped = hit_sp || hit_lo || hit_hi || hit_op;
    wr_en  = access && pwrite_in;
  end

  // Push comes from the core port or the control register; pointer increment only from the control register.
  always_comb begin
    push_now = push_req_in || (wr_en && hit_op && pwdata_in[cspr_pkg::OP_PUSH_BIT]);
    inc_now  = wr_en && hit_op && pwdata_in[cspr_pkg::OP_PTR_INC_BIT];
    inc_word = {pointer_high_byte, pointer_low_byte} + cspr_pkg::PTR_STEP;
  end

  // Next register values; a push takes precedence over a direct pointer write.
  always_comb begin
    next_stack_top_pointer = stack_top_pointer;
    next_pointer_low_byte  = pointer_low_byte;
    next_pointer_high_byte = pointer_high_byte;
    next_stack_wr          = 1'b0;
    next_stack_data        = stack_data;
    if (wr_en && hit_sp) begin
      next_stack_top_pointer = pwdata_in[7:0];
    end
    if (push_now) begin
      next_stack_top_pointer = stack_top_pointer + cspr_pkg::STACK_STEP;
      next_stack_wr          = 1'b1;
      next_stack_data        = push_req_in ? push_data_in : pwdata_in[cspr_pkg::OP_DATA_LSB +: 8];
    end
    if (wr_en && hit_lo) begin
      next_pointer_low_byte = pwdata_in[7:0];
    end
    if (wr_en && hit_hi) begin
      next_pointer_high_byte = pwdata_in[7:0];
    end
    if (inc_now) begin
      next_pointer_low_byte  = inc_word[7:0];
      next_pointer_high_byte = inc_word[15:8];
    end
  end

  // Read data; upper bits and unmapped indices read as zero.
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (access && !pwrite_in) begin
      if (hit_sp) begin
        next_prdata = {24'h00_0000, stack_top_pointer};
      end else if (hit_lo) begin
        next_prdata = {24'h00_0000, pointer_low_byte};
      end else if (hit_hi) begin
        next_prdata = {24'h00_0000, pointer_high_byte};
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  // State registers.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      stack_top_pointer <= cspr_pkg::RST_STACK_TOP;
      pointer_low_byte  <= cspr_pkg::RST_PTR_BYTE;
      pointer_high_byte <= cspr_pkg::RST_PTR_BYTE;
      stack_wr          <= 1'b0;
      stack_data        <= 8'h00;
    end else begin
      stack_top_pointer <= next_stack_top_pointer;
      pointer_low_byte  <= next_pointer_low_byte;
      pointer_high_byte <= next_pointer_high_byte;
      stack_wr          <= next_stack_wr;
      stack_data        <= next_stack_data;
    end
  end

  // Outputs; the stack write names the already incremented pointer.
  always_comb begin
    pready_out            = 1'b1;
    pslverr_out           = access && !mapped;
    prdata_out            = next_prdata;
    stack_wr_out          = stack_wr;
    stack_addr_out        = stack_top_pointer;
    stack_data_out        = stack_data;
    data_pointer_word_out = {pointer_high_byte, pointer_low_byte};
  end

  // A core push with no direct stack pointer write in the same cycle.
  sequence s_push;
    push_req_in && !(wr_en && hit_sp);
  endsequence
  // A push started from the control register with no core push beside it.
  sequence s_ctrl_push;
    wr_en && hit_op && pwdata_in[cspr_pkg::OP_PUSH_BIT] && !push_req_in;
  endsequence
  // The write pulse that follows a push names the incremented location.
  sequence s_slot_written;
    stack_wr_out && stack_addr_out == $past(stack_top_pointer) + cspr_pkg::STACK_STEP;
  endsequence
  a_push_inc_first: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_push |=> s_slot_written)
    else $error("push did not pre-increment stack pointer");
  a_push_data: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    push_req_in |=> stack_data_out == $past(push_data_in))
    else $error("pushed byte not presented");
  a_ctrl_push: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_ctrl_push |=> s_slot_written ##0
      stack_data_out == $past(pwdata_in[cspr_pkg::OP_DATA_LSB +: 8]))
    else $error("control push not carried out");
  a_no_push_quiet: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !push_now |=> !stack_wr_out)
    else $error("stack write without a push");
  a_push_wins: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    push_now && wr_en && hit_sp |=>
      stack_top_pointer == $past(stack_top_pointer) + cspr_pkg::STACK_STEP)
    else $error("pointer write overrode a push");

  // Checks on the stack top pointer register itself.
  a_sp_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    wr_en && hit_sp && !push_now |=> stack_top_pointer == $past(pwdata_in[7:0]))
    else $error("stack pointer write lost");
  a_sp_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !push_now && !(wr_en && hit_sp) |=> $stable(stack_top_pointer))
    else $error("stack pointer changed without cause");

  // Checks on the two data pointer bytes and the word that they form.
  a_low_byte: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    wr_en && hit_lo && !inc_now |=> data_pointer_word_out[7:0] == $past(pwdata_in[7:0]))
    else $error("low byte not in data pointer word");
  a_high_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    wr_en && hit_hi && !inc_now |=> data_pointer_word_out[15:8] == $past(pwdata_in[7:0]))
    else $error("high byte write lost");
  a_word_addr: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    inc_now |=> data_pointer_word_out == $past(data_pointer_word_out) + cspr_pkg::PTR_STEP)
    else $error("data pointer word not advanced");
  a_word_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !inc_now && !(wr_en && (hit_lo || hit_hi)) |=> $stable(data_pointer_word_out))
    else $error("data pointer word changed without cause");

  // Checks on the read path and on the handling of unassigned indices.
  a_reg_reach: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    access && !pwrite_in && hit_sp |-> prdata_out == {24'h00_0000, stack_top_pointer})
    else $error("stack pointer not readable");
  a_read_low: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    access && !pwrite_in && hit_lo |-> prdata_out == {24'h00_0000, pointer_low_byte})
    else $error("low byte not readable");
  a_read_high: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    access && !pwrite_in && hit_hi |-> prdata_out == {24'h00_0000, pointer_high_byte})
    else $error("high byte not readable");
  a_mapped_ok: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    access && mapped |-> !pslverr_out)
    else $error("mapped access flagged as error");
  a_upper_zero: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    prdata_out[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_unmapped_err: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    access && !mapped |-> pslverr_out && prdata_out == 32'h0000_0000)
    else $error("unmapped access not flagged");
  a_unmapped_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    wr_en && !mapped && !push_req_in |=>
      $stable(stack_top_pointer) && $stable(data_pointer_word_out))
    else $error("unmapped write changed a register");
endmodule
`default_nettype wire

// ### core_stack_and_pointer_regs_bench.sv
// Purpose: Self-checking bench for the stack and data pointer register bank.
// Assumes: APB answers with zero wait states; pushes are one-cycle pulses.
// Notes:   Expected values come from a bench model of both pointers.
`default_nettype none
module core_stack_and_pointer_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in, rst_in, psel, penable, pwrite, pready, pslverr, push, swr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  pdat, saddr, sdat, sp, lo, hi;
  logic [15:0] dpw;
  integer      seed = 32'ha4bc;
  int          error_cnt = 0, cmp_count = 0;
  localparam logic [11:0] A_SP = 12'(cspr_pkg::IDX_STACK_TOP) << cspr_pkg::WORD_SHIFT;
  localparam logic [11:0] A_DL = 12'(cspr_pkg::IDX_PTR_LOW) << cspr_pkg::WORD_SHIFT;
  localparam logic [11:0] A_DH = 12'(cspr_pkg::IDX_PTR_HIGH) << cspr_pkg::WORD_SHIFT;
  localparam logic [11:0] A_CT = 12'(cspr_pkg::IDX_OP_CTRL) << cspr_pkg::WORD_SHIFT;
  cspr_regs DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .push_req_in(push),
    .push_data_in(pdat), .stack_wr_out(swr), .stack_addr_out(saddr),
    .stack_data_out(sdat), .data_pointer_word_out(dpw));
  // Free-running 200 MHz clock.
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // Compares one value and counts the result.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do begin @(posedge clk_sys_in); end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Expected data pointer word from its two byte registers.
  function automatic logic [31:0] exp_word(input logic [7:0] h, input logic [7:0] l);
    return {16'h0, h, l};
  endfunction
  // One core push; the stored byte must land at the incremented pointer.
  task automatic do_push(input logic [7:0] d);
    @(posedge clk_sys_in);
    push <= 1'b1; pdat <= d;
    @(posedge clk_sys_in);
    push <= 1'b0;
    #1;
    sp = sp + 8'h01;
    chk("stack write", {31'h0, swr}, 32'h1);
    chk("stack addr", {24'h0, saddr}, {24'h0, sp});
    chk("stack data", {24'h0, sdat}, {24'h0, d});
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    error_cnt++;
    give_verdict();
  end
  // Main sequence: reset values, random pointer traffic, pushes, corners.
  initial begin
    rst_in = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; push = 1'b0; pdat = 8'h00;
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    apb(1'b0, A_SP, 32'h0); chk("sp reset", q, 32'h07);
    chk("sp read err", {31'h0, e}, 32'h0);
    apb(1'b0, A_DL, 32'h0); chk("low reset", q, 32'h0);
    apb(1'b0, A_DH, 32'h0); chk("high reset", q, 32'h0);
    chk("word reset", {16'h0, dpw}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      lo = 8'($random(seed)); hi = 8'($random(seed));
      apb(1'b1, A_DL, {24'h0, lo}); apb(1'b1, A_DH, {24'h0, hi});
      apb(1'b0, A_DL, 32'h0); chk("low", q, {24'h0, lo});
      apb(1'b0, A_DH, 32'h0); chk("high", q, {24'h0, hi});
      chk("word", {16'h0, dpw}, exp_word(hi, lo));
    end
    sp = 8'hfe;
    apb(1'b1, A_SP, 32'hfe);
    for (int i = 0; i < 3; i++) do_push(8'($random(seed)));
    apb(1'b0, A_SP, 32'h0); chk("sp after push", q, {24'h0, sp});
    apb(1'b1, A_CT, 32'h5c01); sp = sp + 8'h01;
    #1;
    chk("ctrl push write", {31'h0, swr}, 32'h1);
    chk("ctrl push addr", {24'h0, saddr}, {24'h0, sp});
    chk("ctrl push data", {24'h0, sdat}, 32'h5c);
    apb(1'b0, A_SP, 32'h0); chk("sp after ctrl push", q, {24'h0, sp});
    apb(1'b1, A_DL, 32'hff); apb(1'b1, A_DH, 32'h12); apb(1'b1, A_CT, 32'h2);
    apb(1'b0, A_CT, 32'h0); chk("ctrl read", q, 32'h0);
    chk("word carry", {16'h0, dpw}, 32'h1300);
    apb(1'b1, 12'h3fc, 32'h55); chk("unmapped err", {31'h0, e}, 32'h1);
    apb(1'b0, 12'h3fc, 32'h0); chk("unmapped data", q, 32'h0);
    apb(1'b0, A_SP, 32'h0); chk("sp kept", q, {24'h0, sp});
    // Reset again in mid-run: both pointers must return to their reset values.
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    apb(1'b0, A_SP, 32'h0); chk("sp re-reset", q, 32'h07);
    chk("word re-reset", {16'h0, dpw}, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
